//--- include/boot_pkg.sv
// Purpose: shared constants and carriers for the boot stream parser
// Assumes: byte-wide boot memory, byte-wide load port
// Notes: flag bit positions and range table drive the parser
package boot_pkg;

  // global header field positions
  localparam int GH_WIDTH_BIT = 0;
  localparam int GH_WAIT_LO = 1;
  localparam int GH_HOLD_LO = 6;
  localparam int GH_BAUD_LO = 8;
  localparam int GH_SIG_LO = 28;

  // values before any header has been read
  localparam logic [3:0] WAIT_RST = 4'hF;
  localparam logic [1:0] HOLD_RST = 2'h3;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;

  // block header layout, bytes arrive lowest first
  localparam logic [3:0] GH_BYTES = 4'h4;
  localparam logic [3:0] BH_BYTES = 4'hA;
  localparam int BH_ADDR_LO = 0;
  localparam int BH_CNT_LO = 32;
  localparam int BH_FLAG_LO = 64;

  // flag word bits
  localparam int FL_ZERO = 0;
  localparam int FL_IGNORE = 1;
  localparam int FL_INIT = 3;
  localparam int FL_FINAL = 15;

  localparam logic [31:0] JUMP_TARGET = 32'hFFA0_0000;

  // permitted load ranges; the last one (dram) is never cleared
  localparam int NUM_RANGES = 10;
  localparam logic [3:0] NUM_CLEAR = 4'h9;
  localparam logic [31:0] RNG_BASE [NUM_RANGES] = '{
    32'hFFA0_0000, 32'hFFA1_0000, 32'hFF80_0000, 32'hFF90_0000,
    32'hFF60_0000, 32'hFF61_0000, 32'hFF40_0000, 32'hFF50_0000,
    32'hFEB0_0000, 32'h0000_0000};
  localparam logic [31:0] RNG_SIZE [NUM_RANGES] = '{
    32'h0000_4000, 32'h0000_4000, 32'h0000_8000, 32'h0000_8000,
    32'h0000_4000, 32'h0000_4000, 32'h0000_8000, 32'h0000_8000,
    32'h0002_0000, 32'h2000_0000};

  typedef enum logic [1:0] {BAUD_500K, BAUD_1M, BAUD_2M} baud_t;

  typedef struct packed {
    logic bus16;
    logic [3:0] wait_st;
    logic [1:0] hold;
    baud_t baud;
  } flash_cfg_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] data;
  } mem_wr_t;

endpackage

//--- test/boot_mem_model.sv
// Purpose: byte-wide boot memory that answers the parser's fetches
// Assumes: one byte per request, LAT idle cycles before each answer
// Notes: idle data line toggles so a stale byte never looks valid
`timescale 1ns/1ps
module boot_mem_model (
  input wire logic CLK,
  input wire logic [3:0] LAT,
  input wire logic REQ,
  input wire logic [31:0] ADDR,
  output logic VALID,
  output logic [7:0] DATA
);
  logic [7:0] mem [256];
  logic [3:0] wait_n;
  initial begin
    VALID = 1'b0;
    DATA = 8'h00;
    wait_n = 4'h0;
  end
  // gap after each answer so the address has moved before the next one
  always @(posedge CLK) begin
    if (VALID || !REQ || wait_n < LAT) begin
      VALID <= 1'b0;
      DATA <= ~DATA;
      wait_n <= (VALID || !REQ) ? 4'h0 : wait_n + 4'h1;
    end else begin
      VALID <= 1'b1;
      DATA <= mem[ADDR[7:0]];
      wait_n <= 4'h0;
    end
  end
endmodule

//--- test/test_boot_stream_parser.sv
// Purpose: self-checking bench for the boot stream parser
// Assumes: range clear skipped, images live in the first 256 bytes
// Notes: header rows first, then full images from both boot sources
`timescale 1ns/1ps
module test_boot_stream_parser;
  import boot_pkg::*;
  typedef struct packed {
    logic [31:0] gh;
    flash_cfg_t cfg;
    logic sig_bad;
  } row_t;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic BOOT_SRC = 1'b0;
  logic [3:0] lat = 4'h0;
  logic INIT_DONE = 1'b0;
  logic PAR_PTR_WE = 1'b0;
  logic SER_PTR_WE = 1'b0;
  logic [31:0] PTR_WDATA = 32'h0;
  logic FETCH_REQ, RD_VALID, INIT_RUN, BOOT_DONE, JUMP, SIG_ERR, RANGE_ERR;
  logic [31:0] FETCH_ADDR, INIT_ADDR, JUMP_ADDR;
  logic [7:0] RD_DATA;
  mem_wr_t MEM_WR;
  flash_cfg_t FLASH_CFG;
  int bad_count = 0;
  int samples_checked = 0;
  int jumps = 0;
  int n;
  logic [39:0] got [$];
  logic [39:0] exp [$];
  row_t rows [5];

  always #2.5 CLK = ~CLK;

  boot_stream_parser #(.CLEAR_EN(1'b0), .SIGNATURE(4'hA)) dut_u (
    .CLK(CLK), .RST(RST), .BOOT_SRC(BOOT_SRC), .FETCH_REQ(FETCH_REQ),
    .FETCH_ADDR(FETCH_ADDR), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .MEM_WR(MEM_WR), .FLASH_CFG(FLASH_CFG), .INIT_RUN(INIT_RUN),
    .INIT_ADDR(INIT_ADDR), .INIT_DONE(INIT_DONE),
    .PAR_PTR_WE(PAR_PTR_WE), .SER_PTR_WE(SER_PTR_WE),
    .PTR_WDATA(PTR_WDATA), .BOOT_DONE(BOOT_DONE), .JUMP(JUMP),
    .JUMP_ADDR(JUMP_ADDR), .SIG_ERR(SIG_ERR), .RANGE_ERR(RANGE_ERR)
  );
  boot_mem_model mem_u (
    .CLK(CLK), .LAT(lat), .REQ(FETCH_REQ), .ADDR(FETCH_ADDR),
    .VALID(RD_VALID), .DATA(RD_DATA)
  );

  always @(posedge CLK) begin
    if (MEM_WR.we === 1'b1) got.push_back({MEM_WR.addr, MEM_WR.data});
    if (JUMP === 1'b1) jumps++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic put(input logic [7:0] b);
    mem_u.mem[n] = b;
    n++;
  endtask
  task automatic put32(input logic [31:0] v);
    for (int i = 0; i < 4; i++) put(v[8*i +: 8]);
  endtask
  task automatic hdr(input logic [31:0] a, c, input logic [15:0] f);
    put32(a);
    put32(c);
    put(f[7:0]);
    put(f[15:8]);
  endtask
  task automatic blank;
    for (int i = 0; i < 256; i++) mem_u.mem[i] = 8'hFF;
    n = 0;
  endtask

  task automatic rst_boot(input logic src, input logic [3:0] l);
    @(posedge CLK);
    RST <= 1'b1;
    BOOT_SRC <= src;
    lat <= l;
    repeat (5) @(posedge CLK);
    #1;
    got.delete();
    jumps = 0;
    check(64'({FETCH_REQ, MEM_WR.we, INIT_RUN, BOOT_DONE, SIG_ERR}), 0);
    check(64'(FLASH_CFG), 64'({1'b0, 4'hF, 2'h3, BAUD_500K}));
    @(posedge CLK) RST <= 1'b0;
  endtask

  task automatic do_init;
    // last init byte is written on the edge that raises INIT_RUN
    @(posedge CLK);
    #1;
    check(64'(INIT_ADDR), 64'(32'hFEB0_0000));
    check(64'(got.size()), 64'd11);
    check(64'(FETCH_REQ), 64'd0);
    // other source's pointer gets a trap address, must be ignored
    @(posedge CLK);
    PTR_WDATA <= 32'h40;
    PAR_PTR_WE <= BOOT_SRC;
    SER_PTR_WE <= !BOOT_SRC;
    @(posedge CLK);
    PTR_WDATA <= 32'h80;
    PAR_PTR_WE <= !BOOT_SRC;
    SER_PTR_WE <= BOOT_SRC;
    @(posedge CLK);
    PAR_PTR_WE <= 1'b0;
    SER_PTR_WE <= 1'b0;
    INIT_DONE <= 1'b1;
    @(posedge CLK) INIT_DONE <= 1'b0;
    @(posedge CLK);
    #1 check(64'(FETCH_ADDR), 64'h80);
  endtask

  task automatic run;
    for (int i = 0; i < 3000; i++) begin
      @(posedge CLK);
      #1;
      if (BOOT_DONE === 1'b1 || SIG_ERR === 1'b1) break;
      if (INIT_RUN === 1'b1) do_init();
    end
    @(posedge CLK);
    #1;
  endtask

  task automatic build_a;
    blank();
    put32(32'hA000_0000 | (32'h15A5A << 11) | 32'h1EB);
    hdr(32'hDEAD_BEEF, 32'd4, 16'h0002);
    put32(32'h0000_0200);
    hdr(32'hFFA0_0000, 32'd6, 16'h0000);
    for (int i = 0; i < 6; i++) put(8'(8'h11 * (i + 1)));
    hdr(32'hFF80_0000, 32'd3, 16'h0001);
    hdr(32'hFEB0_0000, 32'd2, 16'h0008);
    put(8'hAA);
    put(8'hBB);
    n = 8'h40;
    hdr(32'hFFA0_0000, 32'd1, 16'h8000);
    put(8'h55);
    n = 8'h80;
    hdr(32'h0, 32'd4, 16'h0002);
    put32(32'h0);
    hdr(32'hF000_0000, 32'd1, 16'h8000);
    put(8'h77);
  endtask

  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  initial begin
    rows[0] = {32'hA000_0000, 1'b0, 4'h0, 2'h0, BAUD_500K, 1'b0};
    rows[1] = {32'hA000_0106, 1'b0, 4'h3, 2'h0, BAUD_1M, 1'b0};
    rows[2] = {32'hAFFF_FAC1, 1'b1, 4'h0, 2'h3, BAUD_2M, 1'b0};
    rows[3] = {32'h5000_0000, 9'h0, 1'b1};
    rows[4] = {32'hFFFF_FFFF, 9'h0, 1'b1};
    foreach (rows[r]) begin
      blank();
      put32(rows[r].gh);
      hdr(32'hFFA0_0000, 32'd0, 16'h8000);
      rst_boot(1'b0, 4'h1);
      run();
      check(64'(SIG_ERR), 64'(rows[r].sig_bad));
      check(64'(BOOT_DONE), 64'(!rows[r].sig_bad));
      check(64'(got.size()), 0);
      if (!rows[r].sig_bad)
        check(64'(FLASH_CFG), 64'(rows[r].cfg));
    end
    for (int i = 0; i < 6; i++)
      exp.push_back({32'hFFA0_0000 + 32'((i & ~3) + 3 - (i & 3)),
                     8'(8'h11 * (i + 1))});
    for (int i = 0; i < 3; i++)
      exp.push_back({32'hFF80_0000 + 32'(3 - i), 8'h00});
    exp.push_back({32'hFEB0_0003, 8'hAA});
    exp.push_back({32'hFEB0_0002, 8'hBB});
    for (int p = 0; p < 2; p++) begin
      build_a();
      rst_boot(p[0], p ? 4'h3 : 4'h0);
      run();
      check(64'(got.size()), 64'd11);
      foreach (exp[i]) check(64'(got[i]), 64'(exp[i]));
      check(64'(FLASH_CFG), 64'({1'b1, 4'h5, 2'h3, BAUD_1M}));
      check(64'(RANGE_ERR), 64'd1);
      check(64'(BOOT_DONE), 64'd1);
      check(64'(JUMP_ADDR), 64'(JUMP_TARGET));
      check(64'(jumps), 64'd1);
    end
    final_report();
  end
endmodule

//--- verilog/boot_range_check.sv
// Purpose: tells whether a load address lies in a permitted range
// Assumes: ranges do not wrap past the top of the address space
// Notes: purely combinational
`timescale 1ns/1ps
module boot_range_check (
  input wire logic [31:0] addr,
  output logic ok
);
  import boot_pkg::*;

  logic [NUM_RANGES-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_RANGES; g++) begin : g_rng
      // offset compare avoids overflow at the top of memory
      assign hit[g] = (addr >= RNG_BASE[g]) &&
                      ((addr - RNG_BASE[g]) < RNG_SIZE[g]);
    end
  endgenerate

  assign ok = |hit;
endmodule

//--- verilog/boot_stream_parser.sv
// Purpose: walks a boot image byte by byte and loads it into memory
// Assumes: fetch answers come on CLK; init code writes the pointers
// Notes: on-chip ranges are cleared first when CLEAR_EN is set
`timescale 1ns/1ps
module boot_stream_parser #(
  parameter bit CLEAR_EN = 1'b1,
  parameter logic [3:0] SIGNATURE = 4'hA // arbitrary value
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BOOT_SRC,
  output logic FETCH_REQ,
  output logic [31:0] FETCH_ADDR,
  input wire logic RD_VALID,
  input wire logic [7:0] RD_DATA,
  output boot_pkg::mem_wr_t MEM_WR,
  output boot_pkg::flash_cfg_t FLASH_CFG,
  output logic INIT_RUN,
  output logic [31:0] INIT_ADDR,
  input wire logic INIT_DONE,
  input wire logic PAR_PTR_WE,
  input wire logic SER_PTR_WE,
  input wire logic [31:0] PTR_WDATA,
  output logic BOOT_DONE,
  output logic JUMP,
  output logic [31:0] JUMP_ADDR,
  output logic SIG_ERR,
  output logic RANGE_ERR
);
  import boot_pkg::*;

  typedef enum logic [2:0] {
    S_CLEAR, S_GHDR, S_BHDR, S_PAYLOAD, S_FILL, S_INIT, S_DONE, S_ERR
  } state_t;

  typedef struct packed {
    state_t state;
    logic src_s1;
    logic src_s2;
    logic [31:0] parallel_boot_stream_pointer;
    logic [31:0] serial_boot_stream_pointer;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic [31:0] gh;
    logic [79:0] hdr;
    logic [3:0] byte_no;
    logic [31:0] blk_addr;
    logic [31:0] blk_cnt;
    logic [15:0] blk_flags;
    logic [31:0] idx;
    logic [3:0] clr_idx;
    logic [31:0] clr_off;
    mem_wr_t mem;
    flash_cfg_t cfg;
    logic init_run;
    logic done;
    logic jump;
    logic [31:0] jump_addr;
    logic sig_err;
    logic range_err;
  } parser_t;

  parser_t st_q, st_d;
  logic take;
  logic [31:0] wr_addr;
  logic in_rng;
  logic [79:0] hdr_full;

  assign take = st_q.fetch_req & RD_VALID;
  // byte-reversed position inside each group of four
  assign wr_addr = st_q.blk_addr + {st_q.idx[31:2], 2'b00} +
                   {30'h0, ~st_q.idx[1:0]};

  boot_range_check u_rng (
    .addr(wr_addr),
    .ok(in_rng)
  );

  always_comb begin
    st_d = st_q;
    hdr_full = st_q.hdr;
    st_d.mem.we = 1'b0;
    st_d.jump = 1'b0;
    st_d.src_s1 = BOOT_SRC;
    st_d.src_s2 = st_q.src_s1;
    if (take) begin
      if (st_q.src_s2) begin
        st_d.serial_boot_stream_pointer =
          st_q.serial_boot_stream_pointer + 32'h1;
      end else begin
        st_d.parallel_boot_stream_pointer =
          st_q.parallel_boot_stream_pointer + 32'h1;
      end
    end
    case (st_q.state)
      S_CLEAR: begin
        if (!CLEAR_EN || st_q.clr_idx == NUM_CLEAR) begin
          st_d.state = S_GHDR;
        end else begin
          st_d.mem.we = 1'b1;
          st_d.mem.addr = RNG_BASE[st_q.clr_idx] + st_q.clr_off;
          st_d.mem.data = 8'h00;
          if (st_q.clr_off == RNG_SIZE[st_q.clr_idx] - 32'h1) begin
            st_d.clr_off = 32'h0;
            st_d.clr_idx = st_q.clr_idx + 4'h1;
          end else begin
            st_d.clr_off = st_q.clr_off + 32'h1;
          end
        end
      end
      S_GHDR: begin
        if (take) begin
          st_d.gh[st_q.byte_no[1:0]*8 +: 8] = RD_DATA;
          st_d.byte_no = st_q.byte_no + 4'h1;
          if (st_q.byte_no == GH_BYTES - 4'h1) begin
            st_d.byte_no = 4'h0;
            // only the fields below are looked at; rest is unused
            if (RD_DATA[7:4] != SIGNATURE) begin
              st_d.state = S_ERR;
              st_d.sig_err = 1'b1;
            end else begin
              st_d.state = S_BHDR;
              st_d.cfg.bus16 = st_q.gh[GH_WIDTH_BIT];
              st_d.cfg.wait_st = st_q.gh[GH_WAIT_LO +: 4];
              st_d.cfg.hold = st_q.gh[GH_HOLD_LO +: 2];
              case (st_q.gh[GH_BAUD_LO +: 3])
                3'h1: st_d.cfg.baud = BAUD_1M;
                3'h2: st_d.cfg.baud = BAUD_2M;
                default: st_d.cfg.baud = BAUD_500K;
              endcase
            end
          end
        end
      end
      S_BHDR: begin
        if (take) begin
          hdr_full[st_q.byte_no*8 +: 8] = RD_DATA;
          st_d.hdr = hdr_full;
          st_d.byte_no = st_q.byte_no + 4'h1;
          if (st_q.byte_no == BH_BYTES - 4'h1) begin
            st_d.byte_no = 4'h0;
            st_d.idx = 32'h0;
            st_d.blk_addr = hdr_full[BH_ADDR_LO +: 32];
            st_d.blk_cnt = hdr_full[BH_CNT_LO +: 32];
            st_d.blk_flags = hdr_full[BH_FLAG_LO +: 16];
            if (hdr_full[BH_CNT_LO +: 32] == 32'h0) begin
              st_d.state = S_PAYLOAD;
            end else if (hdr_full[BH_FLAG_LO + FL_ZERO] &&
                         !hdr_full[BH_FLAG_LO + FL_IGNORE]) begin
              st_d.state = S_FILL;
            end else begin
              st_d.state = S_PAYLOAD;
            end
          end
        end
      end
      S_PAYLOAD, S_FILL: begin
        if (take || st_q.state == S_FILL || st_q.blk_cnt == 32'h0) begin
          if (st_q.blk_cnt != 32'h0 && !st_q.blk_flags[FL_IGNORE]) begin
            if (in_rng) begin
              st_d.mem.we = 1'b1;
              st_d.mem.addr = wr_addr;
              st_d.mem.data = (st_q.state == S_FILL) ? 8'h00 : RD_DATA;
            end else begin
              st_d.range_err = 1'b1;
            end
          end
          st_d.idx = st_q.idx + 32'h1;
          if (st_q.blk_cnt == 32'h0 ||
              st_q.idx == st_q.blk_cnt - 32'h1) begin
            if (st_q.blk_flags[FL_INIT]) begin
              st_d.state = S_INIT;
              st_d.init_run = 1'b1;
            end else if (st_q.blk_flags[FL_FINAL]) begin
              st_d.state = S_DONE;
            end else begin
              st_d.state = S_BHDR;
            end
          end
        end
      end
      S_INIT: begin
        // init code may move either pointer while the fetcher is idle
        if (PAR_PTR_WE) begin
          st_d.parallel_boot_stream_pointer = PTR_WDATA;
        end
        if (SER_PTR_WE) begin
          st_d.serial_boot_stream_pointer = PTR_WDATA;
        end
        if (INIT_DONE) begin
          st_d.init_run = 1'b0;
          st_d.state = st_q.blk_flags[FL_FINAL] ? S_DONE : S_BHDR;
        end
      end
      S_DONE: begin
        if (!st_q.done) begin
          st_d.done = 1'b1;
          st_d.jump = 1'b1;
          st_d.jump_addr = JUMP_TARGET;
        end
      end
      default: begin
        st_d.state = S_ERR;
      end
    endcase
    st_d.fetch_req = (st_d.state == S_GHDR) || (st_d.state == S_BHDR) ||
                     (st_d.state == S_PAYLOAD && st_d.blk_cnt != 32'h0
                      && !(st_q.state == S_BHDR && st_d.blk_cnt == 32'h0));
    st_d.fetch_addr = st_d.src_s2 ? st_d.serial_boot_stream_pointer
                                  : st_d.parallel_boot_stream_pointer;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= '{state: S_CLEAR, parallel_boot_stream_pointer: PTR_RST,
                serial_boot_stream_pointer: PTR_RST, fetch_addr: PTR_RST,
                cfg: '{bus16: 1'b0, wait_st: WAIT_RST, hold: HOLD_RST,
                       baud: BAUD_500K},
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign FETCH_REQ = st_q.fetch_req;
  assign FETCH_ADDR = st_q.fetch_addr;
  assign MEM_WR = st_q.mem;
  assign FLASH_CFG = st_q.cfg;
  assign INIT_RUN = st_q.init_run;
  assign INIT_ADDR = st_q.blk_addr;
  assign BOOT_DONE = st_q.done;
  assign JUMP = st_q.jump;
  assign JUMP_ADDR = st_q.jump_addr;
  assign SIG_ERR = st_q.sig_err;
  assign RANGE_ERR = st_q.range_err;

  sequence s_gh_last;
    st_q.state == S_GHDR && take && st_q.byte_no == GH_BYTES - 4'h1;
  endsequence

  AST_SIG_BAD: assert property (@(posedge CLK) disable iff (RST)
    s_gh_last ##0 RD_DATA[7:4] != SIGNATURE |=>
      st_q.state == S_ERR && SIG_ERR && !FETCH_REQ)
    else $error("bad signature not refused");
  AST_ERR_QUIET: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_ERR |-> !MEM_WR.we && !FETCH_REQ ##1 !MEM_WR.we)
    else $error("activity after signature error");
  AST_CFG_DEF: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_CLEAR |-> FLASH_CFG.hold == HOLD_RST &&
      FLASH_CFG.wait_st == WAIT_RST && !FLASH_CFG.bus16)
    else $error("config not at default before header");
  AST_HOLD_TAKE: assert property (@(posedge CLK) disable iff (RST)
    s_gh_last ##0 RD_DATA[7:4] == SIGNATURE |=>
      FLASH_CFG.hold == st_q.gh[7:6] && st_q.state == S_BHDR)
    else $error("hold cycles not taken from header");
  AST_BAUD: assert property (@(posedge CLK) disable iff (RST)
    s_gh_last ##0 RD_DATA[7:4] == SIGNATURE ##0 st_q.gh[10:8] == 3'h1
      |=> FLASH_CFG.baud == BAUD_1M)
    else $error("baud pattern 01 not decoded");
  AST_LSB_FIRST: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_BHDR && take && st_q.byte_no == 4'h4 |=>
      st_q.hdr[39:32] == $past(RD_DATA))
    else $error("count low byte misplaced");
  AST_IGNORE: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_PAYLOAD && st_q.blk_flags[FL_IGNORE] |=> !MEM_WR.we)
    else $error("ignored block written");
  AST_ORDER: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_PAYLOAD && take && in_rng &&
      !st_q.blk_flags[FL_IGNORE] && st_q.idx[1:0] == 2'h0 |=>
      MEM_WR.we && MEM_WR.addr == $past(st_q.blk_addr) +
      $past({st_q.idx[31:2], 2'b11}) && MEM_WR.data == $past(RD_DATA))
    else $error("payload byte order wrong");
  AST_RANGE: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_PAYLOAD && take && !in_rng &&
      !st_q.blk_flags[FL_IGNORE] |=> !MEM_WR.we && RANGE_ERR)
    else $error("write outside permitted ranges");
  AST_INIT_HOLD: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_INIT |-> INIT_RUN && !FETCH_REQ)
    else $error("fetch during init block");
  AST_RESUME: assert property (@(posedge CLK) disable iff (RST)
    st_q.state == S_INIT && INIT_DONE && !st_q.blk_flags[FL_FINAL] |=>
      FETCH_REQ && FETCH_ADDR == (st_q.src_s2 ?
      st_q.serial_boot_stream_pointer : st_q.parallel_boot_stream_pointer))
    else $error("resume not from stream pointer");
  AST_JUMP: assert property (@(posedge CLK) disable iff (RST)
    JUMP |-> JUMP_ADDR == JUMP_TARGET && BOOT_DONE ##1 !JUMP)
    else $error("jump target or pulse wrong");
endmodule
